// ===== rtl/spmc_pkg.sv
// Purpose: shared constants for the synthesizer power-down, output mux and modulation control
// Assumes: registers are written only over the three-wire serial port, never read back
// Notes: field positions and frame layout are used by the top and the serial receiver
//
// What this block does
// - three-bit select in bits 8..6 picks the signal driven on the mux output pin
// - modulator-size flag clear gives 18-bit main modulator, set gives 10-bit
// - auxiliary power-down flag set powers down the auxiliary synthesizer
// - auxiliary mode flag set disables aux modulator, aux loop runs integer-N
// - works after power-up with no write ordering or start sequence needed
// - tri-state flag clear drives the mux output pin, set releases it
// - each loaded sample adds a signed offset to the main center frequency
// - sample width of 2 to 12 bits follows how long select is held low
// - magnitude field m from 0 to 13 scales each sample by two to the m
// - address-disable clear means 16-bit addressed frames only, set also accepts bare 2-12 bit samples
// - sample enters the unit on a detector fall, reaches modulator on the next
// - samples are two's-complement signed frequency offsets before scaling
// - full power-down keeps only oscillator, serial port and mux output alive
// - main power-down flag set powers down the main synthesizer
// - main mode flag set disables main modulator, main loop runs integer-N
package spmc_pkg;
   // ==============================================================
   // serial frame layout
   localparam int FRAME_BITS = 16;
   localparam int ADDR_BITS = 4;
   localparam int DATA_BITS = 12;
   localparam int CNT_BITS = 5;
   localparam logic [4:0] CNT_MAX = 5'h1f;
   localparam logic [4:0] FRAME_CNT = 5'h10;
   localparam logic [4:0] MIN_SAMPLE = 5'h02;
   localparam logic [4:0] MAX_SAMPLE = 5'h0c;
   localparam logic [3:0] FULL_WIDTH = 4'hc;

   // ==============================================================
   // register addresses carried in the top four frame bits
   localparam logic [3:0] ADDR_PD_MUX = 4'h6;
   localparam logic [3:0] ADDR_MOD_CTL = 4'h7;
   localparam logic [3:0] ADDR_MOD_DAT = 4'h8;

   // ==============================================================
   // power_down_output_select_control fields
   localparam int PD_WIDTH = 10;
   localparam int PD_FULL = 0;
   localparam int PD_MAIN = 1;
   localparam int PD_MAIN_INT = 2;
   localparam int PD_MAIN_SIZE = 3;
   localparam int PD_AUX = 4;
   localparam int PD_AUX_INT = 5;
   localparam int PD_SEL_LO = 6;
   localparam int PD_SEL_HI = 8;
   localparam int PD_TRI = 9;
   localparam logic [9:0] PD_RESET = 10'h000;

   // output select codes
   localparam logic [2:0] SEL_REF_OSC = 3'h0;
   localparam logic [2:0] SEL_AUX_REF = 3'h1;
   localparam logic [2:0] SEL_MAIN_REF = 3'h2;
   localparam logic [2:0] SEL_AUX_DET = 3'h3;
   localparam logic [2:0] SEL_MAIN_DET = 3'h4;
   localparam logic [2:0] SEL_LOOPBACK = 3'h5;
   localparam logic [2:0] SEL_SER_TEST = 3'h6;

   // ==============================================================
   // modulation_control fields
   localparam int MC_WIDTH = 5;
   localparam int MC_ADDR_DIS = 4;
   localparam logic [4:0] MC_RESET = 5'h00;
   localparam logic [3:0] MAG_MAX = 4'hd;

   // modulator sizes and scaled offset width
   localparam logic [4:0] FRAC_BITS_FULL = 5'h12;
   localparam logic [4:0] FRAC_BITS_SHORT = 5'h0a;
   localparam int OFS_BITS = 25;
   localparam logic [11:0] SAMPLE_RESET = 12'h000;
endpackage

// ===== rtl/spmc_ser_rx.sv
// Purpose: link-side shift register for the three-wire serial port
// Assumes: link clock only toggles while select is low; bits taken on its rising edge
// Notes: contents stay frozen after select rises so the system side can read them
`timescale 1ns/1ps
module spmc_ser_rx
   import spmc_pkg::*;
#(
   parameter int SHIFT_W = FRAME_BITS
) (
   input wire logic ser_clk, // link clock from the host
   input wire logic ser_cs_n, // active-low frame select
   input wire logic ser_data, // serial data pin
   input wire logic mod_in, // alternate modulation data pin
   output logic [SHIFT_W-1:0] sh_data, // last bits seen on ser_data
   output logic [SHIFT_W-1:0] sh_mod, // last bits seen on mod_in
   output logic [CNT_BITS-1:0] bit_cnt // bits taken in the last frame
);
   // ==============================================================
   // frame start tracking
   logic started_q;

   // select high clears the start flag without a link edge, since the clock stops
   always_ff @(posedge ser_clk or posedge ser_cs_n) begin
      if (ser_cs_n) begin
         started_q <= 1'b0;
      end else begin
         started_q <= 1'b1;
      end
   end

   // ==============================================================
   // bit counter: length of select low sets the sample width
   always_ff @(posedge ser_clk) begin
      if (!started_q) begin
         bit_cnt <= 5'h01;
      end else if (bit_cnt != CNT_MAX) begin
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   // ==============================================================
   // shift both pins msb first
   always_ff @(posedge ser_clk) begin
      if (!ser_cs_n) begin
         sh_data <= {sh_data[SHIFT_W-2:0], ser_data};
         sh_mod <= {sh_mod[SHIFT_W-2:0], mod_in};
      end
   end
endmodule

// ===== rtl/spmc_top.sv
// Purpose: power-down, mux output and modulation control of a dual synthesizer
// Assumes: host leaves select high for at least three system clocks between frames
// Notes: registers are write-only; pins read on the system clock pass two flip-flops, the serial receiver takes its pins directly
`timescale 1ns/1ps
module spmc_top
   import spmc_pkg::*;
(
   input wire logic sys_clk, // system clock, 25 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic ser_clk, // serial link clock
   input wire logic ser_cs_n, // serial select, active low
   input wire logic ser_data, // serial data pin
   input wire logic mod_in, // alternate modulation data pin
   input wire logic mod_in_sel, // high: samples come from mod_in
   input wire logic ref_osc, // reference oscillator
   input wire logic aux_ref, // auxiliary divided reference
   input wire logic main_ref, // main divided reference
   input wire logic aux_detector_frequency, // auxiliary detector frequency
   input wire logic main_detector_frequency, // main detector frequency
   output logic mux_out, // mux pin output value
   output logic mux_out_oe, // mux pin drive enable, high drives
   output logic full_pd, // whole device powered down
   output logic main_pd, // main synthesizer powered down
   output logic main_int_mode, // main loop integer-N
   output logic [4:0] main_frac_bits, // main modulator size in bits
   output logic main_mod_en, // main modulator and fractional unit on
   output logic aux_pd, // auxiliary synthesizer powered down
   output logic aux_int_mode, // auxiliary loop integer-N
   output logic aux_mod_en, // auxiliary modulator and fractional unit on
   output logic signed [OFS_BITS-1:0] mod_offset // scaled offset to main modulator
);
   // ==============================================================
   // link side receiver
   logic [FRAME_BITS-1:0] sh_data;
   logic [FRAME_BITS-1:0] sh_mod;
   logic [CNT_BITS-1:0] bit_cnt;

   spmc_ser_rx #(
      .SHIFT_W(FRAME_BITS)
   ) u_rx (
      .ser_clk(ser_clk),
      .ser_cs_n(ser_cs_n),
      .ser_data(ser_data),
      .mod_in(mod_in),
      .sh_data(sh_data),
      .sh_mod(sh_mod),
      .bit_cnt(bit_cnt)
   );

   // ==============================================================
   // pin synchronisers, one pair of flops per pin
   localparam int NSYNC = 8;
   // select idles high, so its flops reset high; a low reset would fake a frame end
   localparam logic [NSYNC-1:0] SYNC_IDLE = 8'h80;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;

   assign pin_raw = {ser_cs_n, mod_in_sel, ser_data, main_detector_frequency,
                     aux_detector_frequency, main_ref, aux_ref, ref_osc};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         // first flop feeds only the second
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               sync1_q[gi] <= SYNC_IDLE[gi];
               sync2_q[gi] <= SYNC_IDLE[gi];
            end else begin
               sync1_q[gi] <= pin_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   logic ref_s, aux_ref_s, main_ref_s, aux_det_s, main_det_s, loop_s, mod_sel_s, cs_s;
   assign {cs_s, mod_sel_s, loop_s, main_det_s, aux_det_s, main_ref_s, aux_ref_s, ref_s} =
      sync2_q;

   // ==============================================================
   // frame end and detector edge detection
   logic cs_prev_q;
   logic det_prev_q;
   logic frame_done;
   logic det_fall;

   // reset to one so a select held high at reset release is no false frame end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cs_prev_q <= 1'b1;
         det_prev_q <= 1'b0;
      end else begin
         cs_prev_q <= cs_s;
         det_prev_q <= main_det_s;
      end
   end

   assign frame_done = cs_s && !cs_prev_q;
   assign det_fall = det_prev_q && !main_det_s;

   // ==============================================================
   // frame decode; receiver contents are frozen while select is high
   logic [3:0] addr;
   logic [11:0] payload;
   logic [FRAME_BITS-1:0] mod_src;
   logic addr_ok;
   logic bare_ok;
   logic [MC_WIDTH-1:0] mc_q;

   assign addr = sh_data[FRAME_BITS-1 -: ADDR_BITS];
   assign payload = sh_data[DATA_BITS-1:0];
   assign mod_src = mod_sel_s ? sh_mod : sh_data;
   assign addr_ok = frame_done && (bit_cnt == FRAME_CNT);
   assign bare_ok = frame_done && mc_q[MC_ADDR_DIS] && (bit_cnt >= MIN_SAMPLE) &&
                    (bit_cnt <= MAX_SAMPLE);

   // ==============================================================
   // power-down and output select register
   logic [PD_WIDTH-1:0] pd_q;

   // zero reset: powered, fractional, 18-bit, pin driven; no ordering needed
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pd_q <= PD_RESET;
      end else if (addr_ok && addr == ADDR_PD_MUX) begin
         pd_q <= payload[PD_WIDTH-1:0];
      end
   end

   // ==============================================================
   // modulation control register

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mc_q <= MC_RESET;
      end else if (addr_ok && addr == ADDR_MOD_CTL) begin
         mc_q <= payload[MC_WIDTH-1:0];
      end
   end

   // ==============================================================
   // modulation sample register and its width
   logic [11:0] sample_q;
   logic [3:0] sample_w_q;
   logic mod_addr_ok;

   assign mod_addr_ok = addr_ok && (mod_src[FRAME_BITS-1 -: ADDR_BITS] == ADDR_MOD_DAT);

   // addressed frames carry a full 12-bit sample; bare frames carry cnt bits
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sample_q <= SAMPLE_RESET;
         sample_w_q <= FULL_WIDTH;
      end else if (mod_addr_ok) begin
         sample_q <= mod_src[DATA_BITS-1:0];
         sample_w_q <= FULL_WIDTH;
      end else if (bare_ok) begin
         sample_q <= mod_src[DATA_BITS-1:0];
         sample_w_q <= bit_cnt[3:0];
      end
   end

   // ==============================================================
   // sign extension from the sample width
   function automatic logic signed [11:0] spmc_sext(input logic [11:0] raw,
                                                    input logic [3:0] w);
      logic [3:0] sh;
      logic signed [11:0] t;
      sh = FULL_WIDTH - w;
      t = $signed(raw << sh);
      return t >>> sh;
   endfunction

   // ==============================================================
   // two-stage modulation pipeline on detector falling edges
   logic signed [11:0] unit_q;
   logic [3:0] mag_eff;
   logic signed [OFS_BITS-1:0] unit_ext;

   // out-of-range magnitudes clamp so the shift never overflows the offset
   assign mag_eff = (mc_q[3:0] > MAG_MAX) ? MAG_MAX : mc_q[3:0];
   assign unit_ext = {{(OFS_BITS-DATA_BITS){unit_q[11]}}, unit_q};

   // a new sample needs two falls to reach the modulator
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         unit_q <= 12'sh000;
         mod_offset <= 25'sh0000000;
      end else if (det_fall) begin
         unit_q <= spmc_sext(sample_q, sample_w_q);
         mod_offset <= unit_ext <<< mag_eff;
      end
   end

   // ==============================================================
   // power and mode outputs, full power-down overrides both loops
   assign full_pd = pd_q[PD_FULL];
   assign main_pd = pd_q[PD_MAIN] || pd_q[PD_FULL];
   assign aux_pd = pd_q[PD_AUX] || pd_q[PD_FULL];
   assign main_int_mode = pd_q[PD_MAIN_INT];
   assign aux_int_mode = pd_q[PD_AUX_INT];
   assign main_mod_en = !pd_q[PD_MAIN_INT] && !main_pd;
   assign aux_mod_en = !pd_q[PD_AUX_INT] && !aux_pd;
   assign main_frac_bits = pd_q[PD_MAIN_SIZE] ? FRAC_BITS_SHORT : FRAC_BITS_FULL;

   // ==============================================================
   // output mux; stays alive under full power-down, loopback is the only echo
   logic test_tgl_q;

   // serial test output toggles once per received frame
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         test_tgl_q <= 1'b0;
      end else if (frame_done) begin
         test_tgl_q <= !test_tgl_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mux_out <= 1'b0;
      end else begin
         unique case (pd_q[PD_SEL_HI:PD_SEL_LO])
            SEL_REF_OSC: mux_out <= ref_s;
            SEL_AUX_REF: mux_out <= aux_ref_s;
            SEL_MAIN_REF: mux_out <= main_ref_s;
            SEL_AUX_DET: mux_out <= aux_det_s;
            SEL_MAIN_DET: mux_out <= main_det_s;
            SEL_LOOPBACK: mux_out <= loop_s;
            SEL_SER_TEST: mux_out <= test_tgl_q;
            default: mux_out <= 1'b0;
         endcase
      end
   end

   assign mux_out_oe = !pd_q[PD_TRI];

   // ==============================================================
   // checks
   mux_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      pd_q[PD_SEL_HI:PD_SEL_LO] == SEL_MAIN_DET |=> mux_out == $past(main_det_s))
      else $error("mux output does not follow main detector");

   frac_size_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(pd_q[PD_MAIN_SIZE]) |-> main_frac_bits == 5'h0a ##1 $stable(main_frac_bits))
      else $error("main modulator size wrong after flag set");

   aux_power_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (pd_q[PD_AUX] && !aux_mod_en) || !pd_q[PD_AUX] && (aux_pd == pd_q[PD_FULL]))
      else $error("auxiliary power state wrong");

   tri_pin_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      addr_ok && addr == ADDR_PD_MUX |=> mux_out_oe == !$past(payload[PD_TRI]))
      else $error("mux pin enable does not follow write");

   sample_width_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bare_ok && !mod_addr_ok |=> sample_w_q == $past(bit_cnt[3:0]))
      else $error("sample width not taken from frame length");

   bad_frame_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      frame_done && !mc_q[MC_ADDR_DIS] && bit_cnt != FRAME_CNT
      |=> $stable(sample_q) && $stable(pd_q) && $stable(mc_q))
      else $error("short addressed frame changed a register");

   mod_pipe_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !det_fall |=> $stable(mod_offset) && $stable(unit_q))
      else $error("modulation pipeline moved without a detector fall");

   scale_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      det_fall && mc_q[3:0] >= MAG_MAX |=> mod_offset == ($past(unit_ext) <<< 13))
      else $error("magnitude clamp wrong");

   main_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      pd_q[PD_MAIN_INT] |-> !main_mod_en && main_int_mode)
      else $error("main modulator on in integer mode");

   loopback_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      pd_q[PD_SEL_HI:PD_SEL_LO] == SEL_LOOPBACK |=> mux_out == $past(loop_s))
      else $error("mux output does not echo serial data");

   size_full_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !pd_q[PD_MAIN_SIZE] |-> main_frac_bits == FRAC_BITS_FULL)
      else $error("main modulator not full size with flag clear");

   aux_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      pd_q[PD_AUX_INT] |-> aux_int_mode && !aux_mod_en)
      else $error("auxiliary modulator on in integer mode");

   main_power_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      pd_q[PD_MAIN] |-> main_pd && !main_mod_en)
      else $error("main synthesizer not powered down");

   full_power_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      pd_q[PD_FULL] |-> main_pd && aux_pd && !main_mod_en && !aux_mod_en)
      else $error("full power-down left a loop running");

   reset_state_a: assert property (@(posedge sys_clk)
      sys_rst |=> mux_out_oe && !full_pd && !main_pd && !aux_pd && mod_offset == 25'sh0000000)
      else $error("state after reset not powered and driven");
endmodule

// ===== test/spmc_host_model.sv
// Purpose: host side of the three-wire port, sending addressed and bare frames
// Assumes: link clock of 6 ns, running only while select is low
// Notes: idle data lines show the inverse of their last bit so no stale value looks valid
`timescale 1ns/1ps
module spmc_host_model (
   output logic ser_clk, // link clock to the device
   output logic ser_cs_n, // frame select, active low
   output logic ser_data, // serial data pin
   output logic mod_in // alternate modulation data pin
);
   // ==============================================================
   // idle state
   // select high and clock still before the first frame
   initial begin
      ser_clk = 1'b0;
      ser_cs_n = 1'b1;
      ser_data = 1'b0;
      mod_in = 1'b1;
   end

   // ==============================================================
   // frame sender
   // select stays low for exactly n bits, which sets the sample width
   task automatic send(input logic [15:0] v, input int n, input bit on_mod);
      int i;
      ser_cs_n = 1'b0;
      #3;
      // the unused pin toggles every bit, so the device cannot lean on it
      for (i = n - 1; i >= 0; i--) begin
         if (on_mod) begin
            mod_in = v[i];
            ser_data = ~ser_data;
         end else begin
            ser_data = v[i];
            mod_in = ~mod_in;
         end
         #3 ser_clk = 1'b1;
         #3 ser_clk = 1'b0;
      end
      #3 ser_cs_n = 1'b1;
      ser_data = ~ser_data;
      mod_in = ~mod_in;
      // gap well above three system clocks before the next frame
      #200;
   endtask
endmodule

// ===== test/synth_powerdown_mux_modulation_ctrl_bench.sv
// Purpose: self-checking bench for power-down, mux output and modulation control
// Assumes: host model in its own file, system clock 40 ns, link clock 6 ns
// Notes: ordinary register cases run from a table; refusals and reset are written by hand
`timescale 1ns/1ps
module synth_powerdown_mux_modulation_ctrl_bench;
   import spmc_pkg::*;
   typedef struct packed {logic [9:0] pd; logic [7:0] flags; logic [4:0] frac;} spmc_row_s;
   typedef struct packed {logic [4:0] mc; logic [11:0] s; logic [4:0] n; logic on_mod;} spmc_mod_s;

   // ==============================================================
   // signals
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic mod_in_sel = 1'b0;
   logic [4:0] src = 5'h00; // detector, aux detector, main ref, aux ref, oscillator
   wire logic ser_clk;
   wire logic ser_cs_n;
   wire logic ser_data;
   wire logic mod_in;
   logic mux_out, mux_out_oe, full_pd, main_pd, main_int_mode, main_mod_en;
   logic aux_pd, aux_int_mode, aux_mod_en;
   logic [4:0] main_frac_bits;
   logic signed [OFS_BITS-1:0] mod_offset;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [11:0] prev_smp = 12'h000;
   logic tgl = 1'b0;
   // flags: full, main pd, main int, main mod on, aux pd, aux int, aux mod on, pin driven
   spmc_row_s rows [9] = '{'{10'h000, 8'h13, 5'h12}, '{10'h001, 8'hc9, 5'h12},
      '{10'h002, 8'h43, 5'h12}, '{10'h004, 8'h23, 5'h12}, '{10'h008, 8'h13, 5'h0a},
      '{10'h010, 8'h19, 5'h12}, '{10'h020, 8'h15, 5'h12}, '{10'h200, 8'h12, 5'h12},
      '{10'h22c, 8'h24, 5'h0a}};
   spmc_mod_s mods [7] = '{'{5'h00, 12'h7ff, 5'h10, 1'b0}, '{5'h0d, 12'h800, 5'h10, 1'b0},
      '{5'h0f, 12'hfff, 5'h10, 1'b0}, '{5'h04, 12'h123, 5'h10, 1'b0},
      '{5'h10, 12'hffe, 5'h02, 1'b0}, '{5'h13, 12'h801, 5'h0c, 1'b1},
      '{5'h10, 12'h555, 5'h0c, 1'b0}};

   // ==============================================================
   // clock, timeout and instances
   always #20 sys_clk = ~sys_clk;

   // a hang ends the run as a failure rather than stalling forever
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end

   spmc_host_model host (.ser_clk(ser_clk), .ser_cs_n(ser_cs_n), .ser_data(ser_data),
      .mod_in(mod_in));

   spmc_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_cs_n(ser_cs_n),
      .ser_data(ser_data), .mod_in(mod_in), .mod_in_sel(mod_in_sel), .ref_osc(src[0]),
      .aux_ref(src[1]), .main_ref(src[2]), .aux_detector_frequency(src[3]),
      .main_detector_frequency(src[4]), .mux_out(mux_out), .mux_out_oe(mux_out_oe),
      .full_pd(full_pd), .main_pd(main_pd), .main_int_mode(main_int_mode),
      .main_frac_bits(main_frac_bits), .main_mod_en(main_mod_en), .aux_pd(aux_pd),
      .aux_int_mode(aux_int_mode), .aux_mod_en(aux_mod_en), .mod_offset(mod_offset));

   // ==============================================================
   // helpers
   // sign-extend, then shift by the magnitude, clamped at 13
   function automatic logic [24:0] exp_ofs(input logic [11:0] s, input logic [3:0] m);
      logic [24:0] x;
      x = {{13{s[11]}}, s};
      return x << ((m > 4'hd) ? 4'hd : m);
   endfunction

   task check(input string what, input logic [24:0] seen, input logic [24:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // effect lands three or four clocks after select rises, so six is safe
   task frame(input logic [15:0] v, input int n, input bit on_mod);
      host.send(v, n, on_mod);
      repeat (6) @(posedge sys_clk);
   endtask

   task write(input logic [3:0] a, input logic [11:0] p);
      frame({a, p}, 16, 1'b0);
   endtask

   // one falling edge of the main detector, long enough to pass the synchronizer
   task fall;
      @(posedge sys_clk);
      src[4] <= 1'b1;
      repeat (6) @(posedge sys_clk);
      src[4] <= 1'b0;
      repeat (6) @(posedge sys_clk);
   endtask

   task check_pd(input spmc_row_s r);
      check("power flags", {17'h0, full_pd, main_pd, main_int_mode, main_mod_en, aux_pd,
         aux_int_mode, aux_mod_en, mux_out_oe}, {17'h0, r.flags});
      check("modulator size", {20'h0, main_frac_bits}, {20'h0, r.frac});
   endtask

   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ==============================================================
   // main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      check_pd(rows[0]);
      check("offset after reset", mod_offset, 25'h0);
      // power and mode flags from the table
      // 10-bit rows are set with no low dividend write around them
      foreach (rows[i]) begin
         write(ADDR_PD_MUX, {2'h0, rows[i].pd});
         check_pd(rows[i]);
      end
      // mux routing: only the selected source high, then only it low; code 7 drives all sources high and expects low
      for (int c = 0; c < 8; c++) begin
         if (c == 5 || c == 6)
            continue;
         write(ADDR_PD_MUX, {3'h0, c[2:0], 6'h00});
         src <= (c < 5) ? (5'h01 << c) : 5'h1f;
         repeat (6) @(posedge sys_clk);
         check("mux high", {24'h0, mux_out}, {24'h0, c < 5});
         src <= (c < 5) ? ~(5'h01 << c) : 5'h00;
         repeat (6) @(posedge sys_clk);
         check("mux low", {24'h0, mux_out}, 25'h0);
      end
      src <= 5'h00;
      // loopback echoes the data line, idle at the inverse of the last bit sent
      write(ADDR_PD_MUX, {3'h0, SEL_LOOPBACK, 6'h00});
      check("mux loopback", {24'h0, mux_out}, 25'h1);
      // serial test output flips once per received frame
      write(ADDR_PD_MUX, {3'h0, SEL_SER_TEST, 6'h00});
      tgl = mux_out;
      write(ADDR_PD_MUX, {3'h0, SEL_SER_TEST, 6'h00});
      check("mux test toggle", {24'h0, mux_out}, {24'h0, ~tgl});
      // modulation: first fall still shows the older sample, second the new one
      foreach (mods[i]) begin
         write(ADDR_MOD_CTL, {7'h00, mods[i].mc});
         mod_in_sel <= mods[i].on_mod;
         repeat (4) @(posedge sys_clk);
         if (mods[i].n == 5'h10)
            write(ADDR_MOD_DAT, mods[i].s);
         else
            frame({4'h0, mods[i].s}, mods[i].n, mods[i].on_mod);
         fall();
         check("offset first fall", mod_offset, exp_ofs(prev_smp, mods[i].mc[3:0]));
         fall();
         check("offset second fall", mod_offset, exp_ofs(mods[i].s, mods[i].mc[3:0]));
         check("offset sign", {24'h0, mod_offset[24]}, {24'h0, mods[i].s[11]});
         prev_smp = mods[i].s;
         mod_in_sel <= 1'b0;
      end
      // a bare frame must be ignored while addresses are expected
      write(ADDR_MOD_CTL, 12'h000);
      frame(16'h00aa, 12, 1'b0);
      fall();
      fall();
      check("bare frame refused", mod_offset, 25'h0000555);
      // unknown address leaves the power register alone
      write(ADDR_PD_MUX, 12'h22c);
      write(4'hf, 12'h3ff);
      check_pd(rows[8]);
      // a second reset in mid-run restores every default
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      check_pd(rows[0]);
      check("offset after second reset", mod_offset, 25'h0);
      complete_run();
   end
endmodule
